// ==== art_timer.sv ====
// Behaviour
// - Timer value is two 8-bit byte counters, low and high, forming 16 bits.
// - Split bit zero: both bytes run as one 16-bit auto-reload counter.
// - 16-bit wrap loads reload pair and sets high overflow flag.
// - 16-bit mode: interrupt on each overflow when timer interrupt enabled.
// - 16-bit mode: low-byte wrap also interrupts when low irq enable set.
// - Split bit set: two 8-bit counters, each reloading from its own byte.
// - Split mode: run bit gates high byte only; low byte always counts.
// - Per-byte select: 1 system clock; 0 picks divide-12 or external divide-8.
// - External divide-by-8 tick is synchronised to the system clock.
// - Split mode: each byte's wrap sets its own overflow flag.
// - Split mode: high overflow interrupts; low too when low irq enabled.
// - Hardware never clears overflow flags; software clears and reads them.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module art_timer
	import art_pkg::*;
(
	// Clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_n,
	// Register port
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	// External oscillator level, divided by 8 inside the timer
	input  wire logic       i_ext_clk,
	// Interrupt enable and request
	input  wire logic       i_timer_interrupt_enable,
	output logic            o_irq
);

	// ==========================================
	// State
	logic [7:0] timer_control;
	logic [7:0] clock_select_register;
	logic [7:0] reload_low_byte;
	logic [7:0] reload_high_byte;
	logic [7:0] count_low_byte;
	logic [7:0] count_high_byte;
	logic [3:0] sys_div_cnt;
	logic [2:0] ext_div_cnt;
	logic       ext_sync1;
	logic       ext_sync2;
	logic       ext_prev;
	logic       ext_tick;
	logic       sys12_tick;
	logic       irq_pulse;
	logic [7:0] rdata;

	// ==========================================
	// Next values
	logic [7:0] next_timer_control;
	logic [7:0] next_clock_select_register;
	logic [7:0] next_reload_low_byte;
	logic [7:0] next_reload_high_byte;
	logic [7:0] next_count_low_byte;
	logic [7:0] next_count_high_byte;
	logic [3:0] next_sys_div_cnt;
	logic [2:0] next_ext_div_cnt;
	logic       next_ext_tick;
	logic       next_sys12_tick;
	logic       next_irq;
	logic [7:0] next_rdata;

	// ==========================================
	// Divide-by-12 tick
	always_comb
	begin
		next_sys12_tick  = 1'b0;
		next_sys_div_cnt = sys_div_cnt + 4'h1;
		if (sys_div_cnt == 4'(SYS_DIV - 1))
		begin
			next_sys_div_cnt = 4'h0;
			next_sys12_tick  = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sys_div_cnt <= 4'h0;
			sys12_tick  <= 1'b0;
		end
		else
		begin
			sys_div_cnt <= next_sys_div_cnt;
			sys12_tick  <= next_sys12_tick;
		end
	end

	// ==========================================
	// External divide-by-8 tick
	always_comb
	begin
		next_ext_tick    = 1'b0;
		next_ext_div_cnt = ext_div_cnt;
		if (ext_sync2 && !ext_prev)
		begin
			next_ext_div_cnt = ext_div_cnt + 3'h1;
			if (ext_div_cnt == 3'(EXT_DIV - 1))
				next_ext_tick = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ext_div_cnt <= 3'h0;
			ext_sync1   <= 1'b0;
			ext_sync2   <= 1'b0;
			ext_prev    <= 1'b0;
			ext_tick    <= 1'b0;
		end
		else
		begin
			ext_div_cnt <= next_ext_div_cnt;
			ext_sync1   <= i_ext_clk;
			ext_sync2   <= ext_sync1;
			ext_prev    <= ext_sync2;
			ext_tick    <= next_ext_tick;
		end
	end

	// ==========================================
	// Counters, flags and registers
	logic split;
	logic slow_tick;
	logic low_tick;
	logic high_tick;
	logic low_wrap;
	logic high_wrap;
	logic full_wrap;

	always_comb
	begin
		split     = timer_control[BIT_SPLIT];
		slow_tick = timer_control[BIT_EXT_TICK] ? ext_tick : sys12_tick;
		low_tick  = clock_select_register[BIT_LOW_CLK_SEL] ? 1'b1 : slow_tick;
		high_tick = clock_select_register[BIT_HIGH_CLK_SEL] ? 1'b1 : slow_tick;
		low_wrap  = 1'b0;
		high_wrap = 1'b0;
		full_wrap = 1'b0;

		next_timer_control         = timer_control;
		next_clock_select_register = clock_select_register;
		next_reload_low_byte       = reload_low_byte;
		next_reload_high_byte      = reload_high_byte;
		next_count_low_byte        = count_low_byte;
		next_count_high_byte       = count_high_byte;

		// Software writes first; hardware events below override
		if (i_wr)
		begin
			if (i_addr == ADDR_TIMER_CONTROL)
				next_timer_control = i_wdata & CONTROL_MASK;
			else if (i_addr == ADDR_CLOCK_SELECT)
				next_clock_select_register = i_wdata & CLKSEL_MASK;
			else if (i_addr == ADDR_RELOAD_LOW)
				next_reload_low_byte = i_wdata;
			else if (i_addr == ADDR_RELOAD_HIGH)
				next_reload_high_byte = i_wdata;
			else if (i_addr == ADDR_COUNT_LOW)
				next_count_low_byte = i_wdata;
			else if (i_addr == ADDR_COUNT_HIGH)
				next_count_high_byte = i_wdata;
		end

		if (!split)
		begin
			// 16-bit mode, low byte select picks the clock
			if (timer_control[BIT_RUN] && low_tick)
			begin
				low_wrap = (count_low_byte == BYTE_MAX);
				if ({count_high_byte, count_low_byte} == {BYTE_MAX, BYTE_MAX})
				begin
					full_wrap            = 1'b1;
					next_count_low_byte  = reload_low_byte;
					next_count_high_byte = reload_high_byte;
				end
				else
				begin
					next_count_low_byte = count_low_byte + 8'h01;
					if (low_wrap)
						next_count_high_byte = count_high_byte + 8'h01;
				end
			end
			if (full_wrap)
				next_timer_control[BIT_HIGH_FLAG] = 1'b1;
		end
		else
		begin
			if (low_tick)
			begin
				low_wrap            = (count_low_byte == BYTE_MAX);
				next_count_low_byte = low_wrap ? reload_low_byte : count_low_byte + 8'h01;
			end
			if (timer_control[BIT_RUN] && high_tick)
			begin
				high_wrap            = (count_high_byte == BYTE_MAX);
				next_count_high_byte = high_wrap ? reload_high_byte : count_high_byte + 8'h01;
			end
			if (high_wrap)
				next_timer_control[BIT_HIGH_FLAG] = 1'b1;
			if (low_wrap)
				next_timer_control[BIT_LOW_FLAG] = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			timer_control         <= CONTROL_RESET;
			clock_select_register <= BYTE_ZERO;
			reload_low_byte       <= BYTE_ZERO;
			reload_high_byte      <= BYTE_ZERO;
			count_low_byte        <= BYTE_ZERO;
			count_high_byte       <= BYTE_ZERO;
		end
		else
		begin
			timer_control         <= next_timer_control;
			clock_select_register <= next_clock_select_register;
			reload_low_byte       <= next_reload_low_byte;
			reload_high_byte      <= next_reload_high_byte;
			count_low_byte        <= next_count_low_byte;
			count_high_byte       <= next_count_high_byte;
		end
	end

	// ==========================================
	// Interrupt request
	always_comb
	begin
		next_irq = 1'b0;
		if (i_timer_interrupt_enable)
		begin
			if (full_wrap || high_wrap)
				next_irq = 1'b1;
			if (low_wrap && timer_control[BIT_LOW_IRQ_EN])
				next_irq = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			irq_pulse <= 1'b0;
		end
		else
		begin
			irq_pulse <= next_irq;
		end
	end

	// ==========================================
	// Read data
	always_comb
	begin
		next_rdata = BYTE_ZERO;
		if (i_rd)
		begin
			if (i_addr == ADDR_TIMER_CONTROL)
				next_rdata = timer_control;
			else if (i_addr == ADDR_CLOCK_SELECT)
				next_rdata = clock_select_register;
			else if (i_addr == ADDR_RELOAD_LOW)
				next_rdata = reload_low_byte;
			else if (i_addr == ADDR_RELOAD_HIGH)
				next_rdata = reload_high_byte;
			else if (i_addr == ADDR_COUNT_LOW)
				next_rdata = count_low_byte;
			else if (i_addr == ADDR_COUNT_HIGH)
				next_rdata = count_high_byte;
			else
				next_rdata = BYTE_ZERO;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rdata <= BYTE_ZERO;
		end
		else
		begin
			rdata <= next_rdata;
		end
	end

	// ==========================================
	// Outputs
	assign o_rdata = rdata;
	assign o_irq   = irq_pulse;

endmodule

// ==== art_pkg.sv ====
package art_pkg;

	// ==========================================
	// Register map
	localparam logic [7:0] ADDR_TIMER_CONTROL  = 8'hc8;
	localparam logic [7:0] ADDR_RELOAD_LOW     = 8'hca;
	localparam logic [7:0] ADDR_RELOAD_HIGH    = 8'hcb;
	localparam logic [7:0] ADDR_COUNT_LOW      = 8'hcc;
	localparam logic [7:0] ADDR_COUNT_HIGH     = 8'hcd;
	localparam logic [7:0] ADDR_CLOCK_SELECT   = 8'he0;

	// ==========================================
	// Control register fields
	localparam int BIT_HIGH_FLAG   = 7;
	localparam int BIT_LOW_FLAG    = 6;
	localparam int BIT_LOW_IRQ_EN  = 5;
	localparam int BIT_SPLIT       = 3;
	localparam int BIT_RUN         = 2;
	localparam int BIT_EXT_TICK    = 0;
	localparam logic [7:0] CONTROL_MASK  = 8'hed;
	localparam logic [7:0] CONTROL_RESET = 8'h00;

	// ==========================================
	// Clock select register fields
	localparam int BIT_LOW_CLK_SEL  = 0;
	localparam int BIT_HIGH_CLK_SEL = 1;
	localparam logic [7:0] CLKSEL_MASK = 8'h03;

	// ==========================================
	// Tick dividers and byte limits
	localparam int SYS_DIV = 12;
	localparam int EXT_DIV = 8;
	localparam logic [7:0] BYTE_MAX  = 8'hff;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

endpackage

// ==== art_timer_props.sv ====
`timescale 1ns/1ps
module art_timer_props
	import art_pkg::*;
(
	// Clock and reset
	input wire logic       i_core_clk,
	input wire logic       i_rst_n,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	// Timer pins
	input wire logic       i_ext_clk,
	input wire logic       i_timer_interrupt_enable,
	input wire logic       o_irq
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	// ==========================================
	// Sequences
	sequence s_ctl_rd;
		i_rd && i_addr == ADDR_TIMER_CONTROL;
	endsequence
	sequence s_wr_rd(a);
		i_wr && i_addr == a ##1 !i_wr ##1 i_rd && i_addr == a;
	endsequence
	// ==========================================
	// Properties
	property p_rdata_idle; !i_rd |=> o_rdata == 8'h00; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside a read");
	property p_irq_off; !i_timer_interrupt_enable [*2] |=> !o_irq; endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
	property p_ctl_unused; s_ctl_rd |=> o_rdata[4] == 1'b0 && o_rdata[1] == 1'b0; endproperty
	a_ctl_unused: assert property (p_ctl_unused) else $error("unused control bits set");
	property p_hi_sticky; s_ctl_rd ##1 o_rdata[BIT_HIGH_FLAG] && !i_wr ##1 s_ctl_rd |=> o_rdata[BIT_HIGH_FLAG]; endproperty
	a_hi_sticky: assert property (p_hi_sticky) else $error("high flag cleared");
	property p_lo_sticky; s_ctl_rd ##1 o_rdata[BIT_LOW_FLAG] && !i_wr ##1 s_ctl_rd |=> o_rdata[BIT_LOW_FLAG]; endproperty
	a_lo_sticky: assert property (p_lo_sticky) else $error("low flag cleared");
	property p_rl_low; s_wr_rd(ADDR_RELOAD_LOW) |=> o_rdata == $past(i_wdata, 3); endproperty
	a_rl_low: assert property (p_rl_low) else $error("reload low readback");
	property p_rl_high; s_wr_rd(ADDR_RELOAD_HIGH) |=> o_rdata == $past(i_wdata, 3); endproperty
	a_rl_high: assert property (p_rl_high) else $error("reload high readback");
	property p_ctl_back; s_wr_rd(ADDR_TIMER_CONTROL) |=> (o_rdata & 8'h2d) == ($past(i_wdata, 3) & 8'h2d); endproperty
	a_ctl_back: assert property (p_ctl_back) else $error("control readback");
endmodule
bind art_timer art_timer_props art_timer_props_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_clk(i_ext_clk),
	.i_timer_interrupt_enable(i_timer_interrupt_enable), .o_irq(o_irq));

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench
	import art_pkg::*;
;
	logic       i_core_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_ext_clk = 0, i_ie = 1;
	logic [7:0] i_addr = 0, i_wdata = 0, o_rdata, d;
	logic       o_irq;
	int         n_fail = 0, cmp_count = 0;
	art_timer art_timer_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_clk(i_ext_clk), .i_timer_interrupt_enable(i_ie), .o_irq(o_irq));
	always #12.5 i_core_clk = ~i_core_clk;
	always #100 i_ext_clk = ~i_ext_clk;
	// ==========================================
	// Bus and compare tasks
	task automatic chk(input string n, input logic [7:0] e, g);
		cmp_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, v);
		@(posedge i_core_clk) {i_addr, i_wdata, i_wr} <= {a, v, 1'b1};
		@(posedge i_core_clk) i_wr <= 1'b0;
	endtask
	task automatic peek(input logic [7:0] a, output logic [7:0] v);
		@(posedge i_core_clk) {i_addr, i_rd} <= {a, 1'b1};
		@(posedge i_core_clk) i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
		logic [7:0] v;
		peek(a, v);
		chk(n, e, v);
	endtask
	task automatic wait_irq;
		for (int k = 0; k < 300 && o_irq !== 1'b1; k++) @(posedge i_core_clk) #1;
		chk("o_irq", 8'h01, {7'h0, o_irq});
	endtask
	// ==========================================
	// Scenarios
	task automatic t_regs;
		rd(ADDR_TIMER_CONTROL, CONTROL_RESET, "control reset");
		wr(ADDR_CLOCK_SELECT, 8'hff);
		rd(ADDR_CLOCK_SELECT, CLKSEL_MASK, "clock select");
		wr(ADDR_RELOAD_LOW, 8'h10);
		rd(ADDR_RELOAD_LOW, 8'h10, "reload low");
		wr(ADDR_RELOAD_HIGH, 8'h20);
		rd(ADDR_RELOAD_HIGH, 8'h20, "reload high");
		wr(ADDR_TIMER_CONTROL, 8'h21);
		rd(ADDR_TIMER_CONTROL, 8'h21, "control");
		rd(8'h01, 8'h00, "unmapped");
		$display("regs test done");
	endtask
	task automatic t_wide;
		wr(ADDR_CLOCK_SELECT, 8'h01);
		wr(ADDR_COUNT_LOW, 8'hfd);
		wr(ADDR_COUNT_HIGH, 8'hff);
		wr(ADDR_TIMER_CONTROL, 8'h04);
		wait_irq;
		rd(ADDR_COUNT_HIGH, 8'h20, "reloaded high");
		rd(ADDR_TIMER_CONTROL, 8'h84, "high flag");
		rd(ADDR_TIMER_CONTROL, 8'h84, "high flag held");
		wr(ADDR_TIMER_CONTROL, 8'h00);
		rd(ADDR_TIMER_CONTROL, 8'h00, "flag cleared");
		wr(ADDR_COUNT_LOW, 8'hfe);
		wr(ADDR_COUNT_HIGH, 8'h00);
		wr(ADDR_TIMER_CONTROL, 8'h24);
		wait_irq;
		rd(ADDR_COUNT_HIGH, 8'h01, "carry");
		rd(ADDR_TIMER_CONTROL, 8'h24, "no flag");
		wr(ADDR_TIMER_CONTROL, 8'h00);
		$display("wide test done");
	endtask
	task automatic t_split;
		logic [7:0] v;
		logic       seen;
		seen = 1'b0;
		wr(ADDR_COUNT_HIGH, 8'h50);
		wr(ADDR_RELOAD_LOW, 8'ha0);
		wr(ADDR_COUNT_LOW, 8'hfe);
		wr(ADDR_TIMER_CONTROL, 8'h28);
		wait_irq;
		rd(ADDR_COUNT_HIGH, 8'h50, "high stopped");
		rd(ADDR_TIMER_CONTROL, 8'h68, "low flag");
		rd(ADDR_TIMER_CONTROL, 8'h68, "low flag held");
		// High byte wrap in split mode
		wr(ADDR_TIMER_CONTROL, 8'h08);
		wr(ADDR_CLOCK_SELECT, 8'h02);
		wr(ADDR_COUNT_HIGH, 8'hfe);
		wr(ADDR_TIMER_CONTROL, 8'h0c);
		wait_irq;
		peek(ADDR_TIMER_CONTROL, v);
		chk("split high flag", 8'h8c, v & 8'hbf);
		// Low wraps with the global enable off
		wr(ADDR_CLOCK_SELECT, 8'h03);
		wr(ADDR_TIMER_CONTROL, 8'h28);
		@(posedge i_core_clk) i_ie <= 1'b0;
		repeat (200) @(posedge i_core_clk) #1 seen = seen | o_irq;
		chk("irq masked", 8'h00, {7'h0, seen});
		$display("split test done");
	endtask
	task automatic t_ticks;
		logic [7:0] v;
		wr(ADDR_CLOCK_SELECT, 8'h00);
		for (int m = 0; m < 2; m++)
		begin
			// Stop counting so the count write cannot meet a tick
			wr(ADDR_TIMER_CONTROL, 8'h00);
			wr(ADDR_COUNT_LOW, 8'h00);
			wr(ADDR_TIMER_CONTROL, 8'h08 | m[7:0]);
			repeat (192) @(posedge i_core_clk);
			peek(ADDR_COUNT_LOW, v);
			d = m ? 8'd3 : 8'd16;
			chk("tick count", 8'h01, {7'h0, v >= d - 8'd1 && v <= d + 8'd1});
		end
		$display("ticks test done");
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		#(3000 * 25);
		n_fail++;
		close_out;
	end
	initial
	begin
		repeat (3) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		t_regs;
		t_wide;
		t_split;
		t_ticks;
		close_out;
	end
endmodule
